// ==== hw/fsc_defs.vh ====
/*
 * Register map, field positions and reset values for the fan sensor
 * configuration and tachometer register block.
 * Assumes an outside two-wire bus engine that hands over byte accesses.
 */
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define FSC_ADDR_CFG         8'h03
`define FSC_ADDR_CFG_ALT     8'h09
`define FSC_ADDR_ONESHOT     8'h0f
`define FSC_ADDR_TACH_LO     8'h46
`define FSC_ADDR_TACH_HI     8'h47
`define FSC_ADDR_HYST        8'h4f

// ****************************************
// field positions and masks
// ****************************************
`define FSC_CFG_FAULT_MASK   7
`define FSC_CFG_IDLE         6
`define FSC_CFG_PWM_OFF_IDLE 5
`define FSC_CFG_FLT_FILTER   0
`define FSC_CFG_WMASK        8'he1
`define FSC_HYST_WMASK       8'h1f

// ****************************************
// reset values and counts
// ****************************************
`define FSC_CFG_RST          8'h00
`define FSC_HYST_RST         8'h04
`define FSC_TACH_RST         16'h0000
`define FSC_FLT_RUN          2'h3

`endif

// ==== hw/fsc_regs.v ====
/*
 * Configuration, lookup-table hysteresis and fan tachometer period
 * registers, plus the conversion scheduler, remote fault filter, table
 * step tracking and idle handling of the PWM output.
 * Assumes a bus engine on clk_sys_i giving single-cycle read and write
 * strobes, and an analog front end that answers each conversion request
 * with one result pulse carrying remote temperature and limits.
 * Temperatures and limits are two's complement whole degrees.
 * Reset is synchronous; the tach pin is asynchronous to the clock.
 */
// How it works
// - hysteresis holds five bits, one degree per count, resets to four.
// - hysteresis bits 7:5 and configuration bits 4:1 always read zero.
// - configuration bit 7 clear lets faults pull the fault pin low.
// - configuration bit 7 set keeps the fault pin released always.
// - bit 6 clear runs conversions, comparisons and PWM updates nonstop.
// - bit 6 set enters idle; periodic conversions stop.
// - in idle, any write to 0x0f starts exactly one conversion cycle.
// - bit 5 clear keeps the fan waveform on the PWM pin in idle.
// - bit 5 set forces PWM to its polarity-defined off level in idle.
// - bit 0 clear raises remote fault on any single out-of-limit result.
// - bit 0 set needs three consecutive out-of-limit results for a fault.
// - read-only 16-bit tachometer period from the latest measurement.
// - low byte read at 46 freezes the high byte read next at 47.
// - tachometer high byte sits at 47, low byte at 46.
// - result above a 7-bit table threshold selects that entry's duty.

`timescale 1ns/10ps
`default_nettype none
`include "fsc_defs.vh"

module fsc_regs #(
  parameter         LUT_N       = 8,
  parameter         CONV_CYCLES = 100000,
  parameter         TACH_DIV    = 100
) (
  input  wire               clk_sys_i,
  input  wire               rst_i,
  input  wire [7:0]         reg_addr_i,
  input  wire               reg_wr_i,
  input  wire [7:0]         reg_wdata_i,
  input  wire               reg_rd_i,
  output wire [7:0]         reg_rdata_o,
  input  wire               tach_pin_i,
  output wire               conv_req_o,
  input  wire               conv_done_i,
  input  wire [7:0]         remote_temp_i,
  input  wire [7:0]         remote_high_i,
  input  wire [7:0]         remote_low_i,
  input  wire               local_fault_i,
  input  wire [LUT_N*7-1:0] lut_temp_i,
  input  wire [LUT_N*6-1:0] lut_duty_i,
  output wire [5:0]         duty_o,
  input  wire               pwm_wave_i,
  input  wire               pwm_pol_i,
  output wire               pwm_o,
  output wire               alert_out_o,
  output wire               alert_oe_o,
  output wire               remote_fault_o
);

  // ****************************************
  // register storage
  // ****************************************
  reg  [7:0]  cfg_r;
  reg  [4:0]  hyst_r;
  reg  [7:0]  rdata_r;
  reg  [7:0]  tach_hi_lock_r;
  reg  [15:0] tach_period_r;
  reg  [15:0] tach_cnt_r;
  reg  [1:0]  flt_cnt_r;
  reg  [1:0]  flt_cnt_nxt;
  reg         remote_fault_r;
  reg         flt_now;
  reg         alert_oe_r;
  reg         pwm_r;
  reg         conv_req_r;
  reg  [31:0] conv_tmr_r;
  reg  [15:0] tdiv_r;
  reg         tach_s1_r;
  reg         tach_s2_r;
  reg         tach_s3_r;
  reg  [LUT_N-1:0] step_on_r;
  reg  [5:0]  duty_r;
  reg  [5:0]  duty_nxt;
  reg         out_of_lim;
  integer     k;

  // ****************************************
  // bus decode and shared nets
  // ****************************************
  wire wr_cfg  = reg_wr_i &&
                 (reg_addr_i == `FSC_ADDR_CFG ||
                  reg_addr_i == `FSC_ADDR_CFG_ALT);
  wire wr_hyst = reg_wr_i && reg_addr_i == `FSC_ADDR_HYST;
  wire wr_shot = reg_wr_i && reg_addr_i == `FSC_ADDR_ONESHOT;
  wire idle    = cfg_r[`FSC_CFG_IDLE];
  wire tick    = (tdiv_r == TACH_DIV - 1);
  wire tach_rise = tach_s2_r & ~tach_s3_r;
  // reset value goes through a net so only its field bits are taken
  wire [7:0]        hyst_rst = `FSC_HYST_RST;
  wire signed [9:0] temp_x   = {{2{remote_temp_i[7]}}, remote_temp_i};
  wire [LUT_N-1:0]  step_nxt;

  // ****************************************
  // writable registers
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_r  <= `FSC_CFG_RST;
      hyst_r <= hyst_rst[4:0];
    end else begin
      if (wr_cfg)
        cfg_r <= reg_wdata_i & `FSC_CFG_WMASK;
      if (wr_hyst)
        hyst_r <= reg_wdata_i[4:0];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // high byte freezes on the low byte read so a pair is coherent
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_r        <= 8'h00;
      tach_hi_lock_r <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `FSC_ADDR_CFG,
        `FSC_ADDR_CFG_ALT: rdata_r <= cfg_r;
        `FSC_ADDR_HYST:    rdata_r <= {3'h0, hyst_r};
        `FSC_ADDR_TACH_LO: begin
          rdata_r        <= tach_period_r[7:0];
          tach_hi_lock_r <= tach_period_r[15:8];
        end
        `FSC_ADDR_TACH_HI: rdata_r <= tach_hi_lock_r;
        default:           rdata_r <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // tachometer period measurement
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tach_s1_r <= 1'b0;
      tach_s2_r <= 1'b0;
      tach_s3_r <= 1'b0;
    end else begin
      tach_s1_r <= tach_pin_i;
      tach_s2_r <= tach_s1_r;
      tach_s3_r <= tach_s2_r;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i || tick)
      tdiv_r <= 16'h0000;
    else
      tdiv_r <= tdiv_r + 16'h0001;
  end

  // counter saturates at all ones; the period only loads on a tach rising edge
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tach_cnt_r    <= `FSC_TACH_RST;
      tach_period_r <= `FSC_TACH_RST;
    end else if (tach_rise) begin
      tach_period_r <= tach_cnt_r;
      tach_cnt_r    <= `FSC_TACH_RST;
    end else if (tick && tach_cnt_r != 16'hffff) begin
      tach_cnt_r <= tach_cnt_r + 16'h0001;
    end
  end

  // ****************************************
  // conversion scheduling
  // ****************************************
  // leaving idle restarts the interval from zero
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      conv_tmr_r <= 32'h0000_0000;
      conv_req_r <= 1'b0;
    end else if (idle) begin
      conv_tmr_r <= 32'h0000_0000;
      conv_req_r <= wr_shot;
    end else if (conv_tmr_r == CONV_CYCLES - 1) begin
      conv_tmr_r <= 32'h0000_0000;
      conv_req_r <= 1'b1;
    end else begin
      conv_tmr_r <= conv_tmr_r + 32'h0000_0001;
      conv_req_r <= 1'b0;
    end
  end

  // ****************************************
  // remote fault filter
  // ****************************************
  // counting goes on with the filter off, so enabling it can fire early
  always @* begin
    out_of_lim = ($signed(remote_temp_i) > $signed(remote_high_i)) ||
                 ($signed(remote_temp_i) < $signed(remote_low_i));
    if (!out_of_lim)
      flt_cnt_nxt = 2'h0;
    else if (flt_cnt_r != `FSC_FLT_RUN)
      flt_cnt_nxt = flt_cnt_r + 2'h1;
    else
      flt_cnt_nxt = flt_cnt_r;
    if (cfg_r[`FSC_CFG_FLT_FILTER])
      flt_now = (flt_cnt_nxt == `FSC_FLT_RUN);
    else
      flt_now = out_of_lim;
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      flt_cnt_r      <= 2'h0;
      remote_fault_r <= 1'b0;
    end else if (conv_done_i) begin
      flt_cnt_r      <= flt_cnt_nxt;
      remote_fault_r <= flt_now;
    end
  end

  // fault pin is open drain: enable high pulls it low
  always @(posedge clk_sys_i) begin
    if (rst_i)
      alert_oe_r <= 1'b0;
    else if (cfg_r[`FSC_CFG_FAULT_MASK])
      alert_oe_r <= 1'b0;
    else
      alert_oe_r <= remote_fault_r | local_fault_i;
  end

  // ****************************************
  // lookup table steps with hysteresis
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < LUT_N; g = g + 1) begin : g_step
      wire [6:0] thr = lut_temp_i[g*7 +: 7];
      wire [8:0] rel = {2'b00, thr} - {4'h0, hyst_r};
      wire       up  = temp_x > $signed({3'b000, thr});
      wire       dn  = temp_x < $signed({rel[8], rel});
      // on above the threshold, off only below the hysteresis floor
      assign step_nxt[g] = up | (step_on_r[g] & ~dn);
    end
  endgenerate

  always @(posedge clk_sys_i) begin
    if (rst_i)
      step_on_r <= {LUT_N{1'b0}};
    else if (conv_done_i)
      step_on_r <= step_nxt;
  end

  // highest active entry wins; none active leaves the fan at zero duty
  // built from the fresh steps so duty follows the result just taken
  always @* begin
    duty_nxt = 6'h00;
    for (k = 0; k < LUT_N; k = k + 1) begin
      if (step_nxt[k])
        duty_nxt = lut_duty_i[k*6 +: 6];
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i)
      duty_r <= 6'h00;
    else if (conv_done_i)
      duty_r <= duty_nxt;
  end

  // ****************************************
  // pwm output in idle
  // ****************************************
  // polarity high means active high, so off level is its inverse
  always @(posedge clk_sys_i) begin
    if (rst_i)
      pwm_r <= 1'b0;
    else if (idle && cfg_r[`FSC_CFG_PWM_OFF_IDLE])
      pwm_r <= ~pwm_pol_i;
    else
      pwm_r <= pwm_wave_i;
  end

  // ****************************************
  // outputs
  // ****************************************
  // fault pin data stays low; only its enable moves
  assign reg_rdata_o    = rdata_r;
  assign conv_req_o     = conv_req_r;
  assign duty_o         = duty_r;
  assign pwm_o          = pwm_r;
  assign alert_out_o    = 1'b0;
  assign alert_oe_o     = alert_oe_r;
  assign remote_fault_o = remote_fault_r;

endmodule // fsc_regs

`default_nettype wire

// ==== sim/fsc_host.sv ====
/* host model: byte writes and reads on the register strobes.
   assumes one caller at a time, clocked by the system clock. */
`timescale 1ns/10ps
`default_nettype none
module fsc_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o,
  output var  logic       wr_o,
  output var  logic       rd_o
);
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
    @(posedge clk_i) #1;
    wr_o = 1'b0;
  endtask
  // callers read the low tach byte before the high one
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i) #1;
    {addr_o, rd_o} = {a, 1'b1};
    @(posedge clk_i) #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
endmodule // fsc_host
`default_nettype wire

// ==== sim/fsc_regs_chk.sv ====
/* checker: readback, alert, conversion and pwm relations.
   assumes binding to fsc_regs, one clock, synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module fsc_regs_chk (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       conv_req_o,
  input wire logic       local_fault_i,
  input wire logic       pwm_wave_i,
  input wire logic       pwm_pol_i,
  input wire logic       pwm_o,
  input wire logic       alert_oe_o
);
  logic [7:0] cfg_r;
  logic [7:0] hyst_r;
  wire cfg_a = reg_addr_i == 8'h03 || reg_addr_i == 8'h09;
  wire one_w = reg_wr_i && reg_addr_i == 8'h0f;
  // shadow copies so readback is judged against what was written
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_r  <= 8'h00;
      hyst_r <= 8'h04;
    end else if (reg_wr_i && cfg_a) begin
      cfg_r  <= reg_wdata_i & 8'he1;
    end else if (reg_wr_i && reg_addr_i == 8'h4f) begin
      hyst_r <= reg_wdata_i & 8'h1f;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence one_pulse;
    conv_req_o ##1 !conv_req_o;
  endsequence
  sequence cfg_rd;
    reg_rd_i && cfg_a;
  endsequence
  AST_CFG_RD: assert property (cfg_rd |=> reg_rdata_o == $past(cfg_r))
    else $error("config readback wrong");
  AST_HYST_RD: assert property (reg_rd_i && reg_addr_i == 8'h4f |=>
    reg_rdata_o == $past(hyst_r)) else $error("hysteresis readback wrong");
  AST_ALERT_ON: assert property (!cfg_r[7] && local_fault_i |=> alert_oe_o)
    else $error("alert not driven");
  AST_ALERT_MASK: assert property (cfg_r[7] |=> !alert_oe_o)
    else $error("alert driven while masked");
  AST_ONESHOT: assert property (cfg_r[6] && one_w |=> one_pulse)
    else $error("one-shot request missing");
  AST_IDLE: assert property (cfg_r[6] && !one_w |=> !conv_req_o)
    else $error("request while idle");
  AST_PWM_RUN: assert property (!(cfg_r[6] && cfg_r[5]) |=>
    pwm_o == $past(pwm_wave_i)) else $error("pwm not following wave");
  AST_PWM_OFF: assert property (cfg_r[6] && cfg_r[5] |=>
    pwm_o == !$past(pwm_pol_i)) else $error("pwm not at off level");
endmodule // fsc_regs_chk
bind fsc_regs fsc_regs_chk i_chk (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wr_i,
  .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .conv_req_o, .local_fault_i,
  .pwm_wave_i, .pwm_pol_i, .pwm_o, .alert_oe_o);
`default_nettype wire

// ==== sim/tb_top.sv ====
/* testbench: reset values, register map, fault filter, idle, table, tach.
   assumes fsc_host for the register strobes; short counts set below. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk_sys_i = 0, rst_i = 1, tach = 0, done = 0, lflt = 0;
  logic        wave = 0, pol = 1, wr, rd, req, pwm, aoe, rflt;
  logic [7:0]  temp = 0, hi = 8'h64, lo = 8'h0a, d, addr, wdata, rdata;
  logic [55:0] thr;
  logic [47:0] duty;
  logic [5:0]  duty_o;
  int          miscompares = 0, checks = 0, c;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) wave <= #1 ~wave;
  // thresholds 20,30,..; duties 1,2,..
  initial for (int k = 0; k < 8; k++) begin
    thr[k*7+:7] = 7'(20 + 10 * k);
    duty[k*6+:6] = 6'(k + 1);
  end
  fsc_host i_host (.clk_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  fsc_regs #(.CONV_CYCLES(50), .TACH_DIV(2)) i_fsc_regs (.clk_sys_i, .rst_i,
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .tach_pin_i(tach), .conv_req_o(req),
    .conv_done_i(done), .remote_temp_i(temp), .remote_high_i(hi),
    .remote_low_i(lo), .local_fault_i(lflt), .lut_temp_i(thr),
    .lut_duty_i(duty), .duty_o(duty_o), .pwm_wave_i(wave), .pwm_pol_i(pol),
    .pwm_o(pwm), .alert_out_o(), .alert_oe_o(aoe), .remote_fault_o(rflt));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input string n, input logic [7:0] e);
    i_host.rd(a, d);
    chk(n, d, e);
  endtask
  task automatic conv(input logic [7:0] t);
    @(posedge clk_sys_i) #1;
    {temp, done} = {t, 1'b1};
    @(posedge clk_sys_i) #1;
    done = 0;
  endtask
  // samples first: a one-shot request lands as the write returns
  task automatic cnt_req(input int n);
    c = 0;
    repeat (n) begin
      c += req;
      @(posedge clk_sys_i) #1;
    end
  endtask
  task automatic tach_edge(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1 tach = 1;
    repeat (10) @(posedge clk_sys_i);
    #1 tach = 0;
  endtask
  task automatic t_reset;
    rdc(8'h03, "cfg", 8'h00);
    rdc(8'h09, "cfg_alt", 8'h00);
    rdc(8'h4f, "hyst", 8'h04);
    rdc(8'h46, "tach_lo", 8'h00);
  endtask
  task automatic t_regs;
    lflt = 1;
    i_host.wr(8'h09, 8'hff);
    rdc(8'h03, "cfg", 8'he1);
    i_host.wr(8'h4f, 8'hff);
    rdc(8'h4f, "hyst", 8'h1f);
    i_host.wr(8'h4f, 8'h04);
    i_host.wr(8'h50, 8'hff);
    rdc(8'h50, "unmapped", 8'h00);
    i_host.wr(8'h03, 8'h00);
    rdc(8'h09, "cfg_alt", 8'h00);
    chk("alert", {7'h0, aoe}, 8'h01);
    lflt = 0;
  endtask
  task automatic t_fault;
    conv(8'h70);
    chk("rfault_hi", {7'h0, rflt}, 8'h01);
    conv(8'h30);
    conv(8'h05);
    chk("rfault_lo", {7'h0, rflt}, 8'h01);
    i_host.wr(8'h03, 8'h01);
    conv(8'h70);
    conv(8'h70);
    conv(8'h30);
    conv(8'h70);
    conv(8'h70);
    chk("rfault_q2", {7'h0, rflt}, 8'h00);
    conv(8'h70);
    chk("rfault_q3", {7'h0, rflt}, 8'h01);
    i_host.wr(8'h03, 8'h00);
    conv(8'h30);
  endtask
  task automatic t_idle;
    i_host.wr(8'h03, 8'h60);
    repeat (2) @(posedge clk_sys_i) #1;
    chk("pwm_off", {7'h0, pwm}, 8'h00);
    pol = 0;
    repeat (2) @(posedge clk_sys_i) #1;
    chk("pwm_off_inv", {7'h0, pwm}, 8'h01);
    pol = 1;
    i_host.wr(8'h03, 8'h40);
    cnt_req(120);
    chk("req_idle", 8'(c), 8'h00);
    i_host.wr(8'h0f, 8'h00);
    cnt_req(60);
    chk("req_oneshot", 8'(c), 8'h01);
    i_host.wr(8'h03, 8'h00);
    cnt_req(60);
    chk("req_run", 8'(c > 0), 8'h01);
  endtask
  task automatic t_lut;
    conv(8'h2d);
    chk("duty_45", {2'h0, duty_o}, 8'h03);
    conv(8'h26);
    chk("duty_38", {2'h0, duty_o}, 8'h03);
    conv(8'h23);
    chk("duty_35", {2'h0, duty_o}, 8'h02);
  endtask
  task automatic t_tach;
    tach_edge(10);
    tach_edge(590);
    repeat (5) @(posedge clk_sys_i);
    i_host.rd(8'h46, d);
    tach_edge(1190);
    repeat (5) @(posedge clk_sys_i);
    rdc(8'h47, "tach_hi_locked", 8'h01);
    i_host.rd(8'h46, d);
    rdc(8'h47, "tach_hi_new", 8'h02);
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1 rst_i = 0;
    t_reset;
    t_regs;
    t_fault;
    t_idle;
    t_lut;
    t_tach;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
